// *** dce_pkg.sv ***
// Shared constants and types for the two-channel edge timing link
package dce_pkg;
  localparam int CLK_NS = 10;
  localparam int DW = 28;
  localparam int AW = 4;
  localparam int TW = 24;
  localparam int RW = 22;
  localparam int NCH = 2;
  localparam int NGATE = 4;
  localparam int HALF_W = 16;
  // Device register addresses
  localparam logic [AW-1:0] A_EDGE = 4'h0;
  localparam logic [AW-1:0] A_DIS = 4'h2;
  localparam logic [AW-1:0] A_CTRL = 4'h4;
  localparam logic [AW-1:0] A_START = 4'h5;
  localparam logic [AW-1:0] A_AUX = 4'h6;
  localparam logic [AW-1:0] A_TIMER = 4'h7;
  localparam logic [AW-1:0] A_FIFO1 = 4'h8;
  localparam logic [AW-1:0] A_FIFO2 = 4'h9;
  localparam logic [AW-1:0] A_IRQ = 4'hC;
  localparam logic [AW-1:0] A_BUS = 4'hE;
  localparam logic [DW-1:0] BUS16_WORD = 28'h0000010;
  // Field positions
  localparam int B_FALL0 = 3;
  localparam int B_QUIET = 0, B_TRIG = 21, B_MRST = 22, B_PRST = 23, B_TSTART = 25, B_TSTOP = 26;
  localparam int OFF_W = 18, B_STOPWAIT = 18, B_SINGLE = 19, B_RETRIG = 20;
  localparam int B_MTRIG = 21, B_MOEN = 22, B_PTRIG = 23, B_POEN = 24;
  localparam int B_FILL = 18, FILL_W = 9, B_PWR = 27;
  localparam int TMR_W = 13;
  localparam int B_IM_HFULL = 13, B_IM_IFULL = 14, B_IM_PLL = 15, B_IM_HEMPTY = 16, B_IM_TMR = 25;
  // Device pin vector positions and their idle levels
  localparam int P_CS = 0, P_WR = 1, P_RD = 2, P_OEN = 3, P_TRIG = 4, P_PU = 5;
  localparam int P_GATE = 6, P_START = 10, P_STOP = 11, P_PLL = 13, NPIN = 14;
  localparam logic [NPIN-1:0] PIN_IDLE = 14'h23EF;
  // Times in ns and derived cycle counts
  localparam int HOLD_MST_NS = 40;
  localparam int HOLD_PRT_NS = 75;
  localparam int STOP_DLY_NS = 7;
  localparam int PROC_LAT_NS = 200;
  localparam int CH_RATE_MHZ = 20;
  localparam int HOLD_MST_CYC = (HOLD_MST_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_PRT_CYC = (HOLD_PRT_NS + CLK_NS - 1) / CLK_NS;
  localparam int STOP_DLY_CYC = (STOP_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROC_LAT_CYC = PROC_LAT_NS / CLK_NS;
  localparam int XFER_GAP_CYC = (1000 + CLK_NS * CH_RATE_MHZ - 1) / (CLK_NS * CH_RATE_MHZ);
  localparam int START2_CYC = 10;
  // Host controller registers and bus cycle timing
  localparam logic [2:0] H_CMD = 3'h0, H_WDATA = 3'h1, H_RDATA = 3'h2, H_STAT = 3'h3, H_PINS = 3'h4;
  localparam int C_RD_B = 4;
  localparam int SETUP_NS = 20, STROBE_NS = 100, HOLDB_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLDB_CYC = (HOLDB_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_SETUP = 2'b01, HS_STROBE = 2'b10, HS_HOLD = 2'b11} dce_hst_t;
endpackage : dce_pkg

// *** dce_bus_if.sv ***
// Pin-level link between the timing device and its host
`timescale 1ns/1ps
interface dce_bus_if;
  import dce_pkg::*;
  logic cs_n, wr_n, rd_n, oen_n, trig, pu_n, h_en, d_en, irq;
  logic [AW-1:0] addr;
  logic [NGATE-1:0] gate;
  logic [DW-1:0] h_dat, d_dat, data;
  logic [NCH-1:0] ef, lf;
  // Resolved data bus level; device drive wins, undriven reads zero
  assign data = d_en ? d_dat : (h_en ? h_dat : '0);
  modport dev (input cs_n, wr_n, rd_n, oen_n, trig, pu_n, addr, gate, data, output d_dat, d_en, ef, lf, irq);
  modport host (output cs_n, wr_n, rd_n, oen_n, trig, pu_n, addr, gate, h_dat, h_en, input data, ef, lf, irq);
endinterface : dce_bus_if

// *** dce_host.sv ***
// Host end: drives the asynchronous bus from a small command register set
`timescale 1ns/1ps
module dce_host
  import dce_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst, // Asynchronous reset, high
  input wire logic [2:0] sw_addr, // Software register address
  input wire logic [DW-1:0] sw_wdata, // Software write data
  input wire logic sw_wr, // Software write strobe
  input wire logic sw_rd, // Software read strobe
  output logic [DW-1:0] sw_rdata, // Read data, cycle after strobe
  dce_bus_if.host bus // Link to the device
);
  typedef struct packed {
    dce_hst_t st;
    logic [3:0] cnt;
    logic rw;
    logic [AW-1:0] a;
    logic [DW-1:0] wdat, rdat, q;
    logic err, cs_n, wr_n, rd_n, h_en, trig, oen_n, pu_n;
    logic [NGATE-1:0] gate;
    logic [DW+2*NCH:0] s1, s2;
  } dce_host_t;

  localparam dce_host_t H_RST = '{st: HS_IDLE, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, oen_n: 1'b1,
    pu_n: 1'b1, gate: '1, default: '0};

  dce_host_t r, next_r;

  // Next state of the bus sequencer and software registers
  always_comb
  begin : p_next
    logic [DW-1:0] d;
    logic [NCH-1:0] ef, lf, rdc;
    logic [AW-1:0] ca;
    d = r.s2[DW-1:0];
    ef = r.s2[DW+:NCH];
    lf = r.s2[DW+NCH+:NCH];
    ca = sw_wdata[AW-1:0];
    next_r = r;
    next_r.s1 = {bus.irq, bus.lf, bus.ef, bus.data};
    next_r.s2 = r.s1;
    rdc = '0;
    if (r.st != HS_IDLE && !r.rw)
    begin
      rdc = {r.a == A_FIFO2, r.a == A_FIFO1};
    end
    unique case (r.st)
      HS_IDLE: next_r.cnt = '0;
      HS_SETUP:
        if (r.cnt == '0)
        begin
          next_r.st = HS_STROBE;
          next_r.cnt = 4'(STROBE_CYC - 1);
          next_r.wr_n = !r.rw;
          next_r.rd_n = r.rw;
        end
        else next_r.cnt = r.cnt - 4'h1;
      HS_STROBE:
        if (r.cnt == '0)
        begin
          next_r.st = HS_HOLD;
          next_r.cnt = 4'(HOLDB_CYC - 1);
          next_r.wr_n = 1'b1;
          next_r.rd_n = 1'b1;
          if (!r.rw) next_r.rdat = d;
        end
        else next_r.cnt = r.cnt - 4'h1;
      HS_HOLD:
        if (r.cnt == '0)
        begin
          next_r.st = HS_IDLE;
          next_r.cs_n = 1'b1;
          next_r.h_en = 1'b0;
        end
        else next_r.cnt = r.cnt - 4'h1;
    endcase
    // Software reads; load-level shown only while that FIFO is not being read
    if (sw_rd)
    begin
      unique case (sw_addr)
        H_WDATA: next_r.q = r.wdat;
        H_RDATA: next_r.q = r.rdat;
        H_STAT: next_r.q = DW'({r.s2[DW+2*NCH], lf & ~rdc, ef, r.err, r.st != HS_IDLE});
        H_PINS: next_r.q = DW'({r.pu_n, r.oen_n, r.trig, r.gate});
        default: next_r.q = '0;
      endcase
    end
    // Software writes; a read command to an empty result FIFO is refused
    if (sw_wr)
    begin
      unique case (sw_addr)
        H_CMD:
          if (r.st != HS_IDLE || (sw_wdata[C_RD_B] && ((ca == A_FIFO1 && ef[0]) || (ca == A_FIFO2 && ef[1]))))
          begin
            next_r.err = 1'b1;
          end
          else
          begin
            next_r.err = 1'b0;
            next_r.a = ca;
            next_r.rw = !sw_wdata[C_RD_B];
            next_r.st = HS_SETUP;
            next_r.cnt = 4'(SETUP_CYC - 1);
            next_r.cs_n = 1'b0;
            next_r.h_en = !sw_wdata[C_RD_B];
          end
        H_WDATA: next_r.wdat = sw_wdata;
        H_PINS: {next_r.pu_n, next_r.oen_n, next_r.trig, next_r.gate} = sw_wdata[NGATE+2:0];
        default: next_r.err = r.err;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst) r <= H_RST;
    else r <= next_r;
  end

  assign sw_rdata = r.q;
  assign bus.cs_n = r.cs_n;
  assign bus.wr_n = r.wr_n;
  assign bus.rd_n = r.rd_n;
  assign bus.addr = r.a;
  assign bus.h_dat = r.wdat;
  assign bus.h_en = r.h_en;
  assign bus.trig = r.trig;
  assign bus.oen_n = r.oen_n;
  assign bus.pu_n = r.pu_n;
  assign bus.gate = r.gate;
endmodule : dce_host

// *** dce_dev.sv ***
// Device end: edge capture, hit and result FIFOs, resets, timer and readout
//
// What this block does
// - Input buffers powered only by power bit.
// - Per-input rising and falling enables; both off disables.
// - Gate pins block each stop edge separately.
// - Software sets disable bits in pairs.
// - Optional stop block until start plus 7 ns.
// - Single-shot bit closes start after first pulse.
// - Retrigger bit lets each start restart timing.
// - Second internal start; one of two 18-bit offsets added.
// - 32-entry hit FIFO per channel.
// - 256-entry result FIFO, rate limited per channel.
// - 28 or 16 bit bus; low enable forces drive.
// - Empty and load-level flags; never read empty.
// - Load-level flags share one threshold.
// - Quiet mode processes only on trigger.
// - Non-quiet processing starts on start and stop.
// - Bit 22 edge, time below; FIFOs at 8, 9.
// - Power-up pin clears everything including configuration.
// - Master reset keeps only configuration.
// - Partial reset also keeps result FIFOs.
// - Inputs blind 40 ns or 75 ns after reset.
// - Measurement timer started by start or stop.
// - Interrupt is OR of masked events.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module dce_dev
  import dce_pkg::*;
#(
  parameter int HIT_DEPTH = 32, // Hit FIFO entries per channel
  parameter int IF_DEPTH = 256 // Result FIFO entries per channel
)
(
  input wire logic ref_clk, // System clock
  input wire logic rst, // Asynchronous reset, high
  input wire logic start_in, // Start hit input
  input wire logic [NCH-1:0] stop_in, // Stop hit inputs
  input wire logic pll_locked, // Core clock lock indication
  output logic diff_power_on, // Input buffer power enable
  dce_bus_if.dev bus // Link to the host
);
  localparam int HA = $clog2(HIT_DEPTH);
  localparam int IA = $clog2(IF_DEPTH);
  localparam int IW = NPIN + DW + AW;

  // Depths must be powers of two that the pointer arithmetic can wrap
  if (HIT_DEPTH != 2 ** HA || IF_DEPTH != 2 ** IA || IA + 1 > FILL_W)
  begin : g_check
    $error("FIFO depth must be a power of two within the fill field");
  end

  typedef struct packed {
    logic [15:0][DW-1:0] cfg;
    logic [IW-1:0] s1, s2;
    logic [NPIN-1:0] pv;
    logic [TW-1:0] now, t0;
    logic [3:0] hold;
    logic seen;
    logic [1:0] sdly;
    logic proc;
    logic [4:0] lat;
    logic [2:0] gap;
    logic [NCH-1:0][HA:0] hwp, hrp;
    logic [NCH-1:0][IA:0] iwp, irp;
    logic [TMR_W-1:0] tmr;
    logic trun, tdone;
    logic [NCH-1:0] half, ef, lf;
    logic [DW-1:0] q;
    logic oe, irq, pwr;
  } dce_dev_t;

  localparam dce_dev_t D_RST = '{s1: {{(DW+AW){1'b0}}, PIN_IDLE}, s2: {{(DW+AW){1'b0}}, PIN_IDLE},
    pv: PIN_IDLE, ef: '1, default: '0};

  dce_dev_t r, next_r;
  logic [NCH-1:0] hpush, ipush;
  logic [NCH-1:0][TW:0] hdat, hq;
  logic [NCH-1:0][RW:0] idat, iq;

  // Edge acceptance: enable bit for the edge and no paired disable
  function automatic logic edge_ok(logic [DW-1:0] c0, logic [DW-1:0] c2, int i, int f);
    logic en;
    en = f != 0 ? c0[B_FALL0+i] : c0[i];
    return en & ~(c2[4*i+2*f] & c2[4*i+2*f+1]);
  endfunction : edge_ok

  // Next state of the whole block
  always_comb
  begin : p_next
    logic [NPIN-1:0] p, rise, fall;
    logic [DW-1:0] d, c5;
    logic [AW-1:0] a;
    logic [NCH-1:0] hfull, hemp, ifull, iemp, rh, fh;
    logic [HA:0] hc;
    logic [IA:0] ic;
    logic [TW-1:0] dt;
    logic quiet, wr_end, rd_go, live, open, st_hit, sp_hit, trig_go, xfer, b16, pu, mrst, prst;
    next_r = r;
    hpush = '0;
    ipush = '0;
    hdat = '0;
    idat = '0;
    rh = '0;
    fh = '0;
    dt = '0;
    sp_hit = 1'b0;
    next_r.s1 = {bus.addr, bus.data, pll_locked, stop_in, start_in, bus.gate, bus.pu_n, bus.trig,
      bus.oen_n, bus.rd_n, bus.wr_n, bus.cs_n};
    next_r.s2 = r.s1;
    p = r.s2[NPIN-1:0];
    d = r.s2[NPIN+:DW];
    a = r.s2[NPIN+DW+:AW];
    next_r.pv = p;
    rise = p & ~r.pv;
    fall = ~p & r.pv;
    c5 = r.cfg[A_START];
    quiet = r.cfg[A_CTRL][B_QUIET];
    b16 = r.cfg[A_BUS] == BUS16_WORD;
    wr_end = rise[P_WR] & ~p[P_CS];
    rd_go = fall[P_RD] & ~p[P_CS];
    next_r.now = r.now + 1'b1;
    // FIFO occupancy
    for (int c = 0; c < NCH; c++)
    begin
      hc = r.hwp[c] - r.hrp[c];
      ic = r.iwp[c] - r.irp[c];
      hfull[c] = hc[HA];
      hemp[c] = hc == '0;
      ifull[c] = ic[IA];
      iemp[c] = ic == '0;
      next_r.lf[c] = int'(ic) >= int'(r.cfg[A_AUX][B_FILL+:FILL_W]);
    end
    next_r.ef = iemp;
    // Configuration writes; the result FIFO addresses are read only
    if (wr_end && a != A_FIFO1 && a != A_FIFO2)
    begin
      next_r.cfg[a] = d;
    end
    pu = ~p[P_PU];
    mrst = (wr_end & a == A_CTRL & d[B_MRST]) | (p[P_TRIG] & ~quiet & c5[B_MTRIG]) | (~p[P_OEN] & quiet & c5[B_MOEN]);
    prst = (wr_end & a == A_CTRL & d[B_PRST]) | (p[P_TRIG] & ~quiet & c5[B_PTRIG]) | (~p[P_OEN] & quiet & c5[B_POEN]);
    trig_go = quiet & (rise[P_TRIG] | (wr_end & a == A_CTRL & d[B_TRIG]));
    // Inputs live only with power on and the post-reset blind time over
    next_r.pwr = r.cfg[A_AUX][B_PWR];
    live = r.pwr & r.hold == '0;
    if (r.hold != '0) next_r.hold = r.hold - 4'h1;
    // Start channel
    st_hit = live & ((rise[P_START] & edge_ok(r.cfg[A_EDGE], r.cfg[A_DIS], 0, 0))
      | (fall[P_START] & edge_ok(r.cfg[A_EDGE], r.cfg[A_DIS], 0, 1)))
      & (~r.seen | (c5[B_RETRIG] & ~c5[B_SINGLE]));
    if (st_hit)
    begin
      next_r.seen = 1'b1;
      next_r.t0 = r.now;
      next_r.sdly = c5[B_STOPWAIT] ? 2'(STOP_DLY_CYC) : 2'h0;
    end
    else if (r.sdly != '0) next_r.sdly = r.sdly - 2'h1;
    open = ~c5[B_STOPWAIT] | (r.seen & r.sdly == '0);
    // Stop channels into the hit FIFOs
    for (int c = 0; c < NCH; c++)
    begin
      rh[c] = rise[P_STOP+c] & edge_ok(r.cfg[A_EDGE], r.cfg[A_DIS], c + 1, 0) & ~p[P_GATE+2*c];
      fh[c] = fall[P_STOP+c] & edge_ok(r.cfg[A_EDGE], r.cfg[A_DIS], c + 1, 1) & ~p[P_GATE+2*c+1];
      sp_hit = sp_hit | (live & open & (rh[c] | fh[c]));
      hpush[c] = live & open & (rh[c] | fh[c]) & ~hfull[c];
      hdat[c] = {rh[c], r.now};
      if (hpush[c]) next_r.hwp[c] = r.hwp[c] + 1'b1;
    end
    // Post-processing start, first-result latency and transfer pacing
    if (!r.proc && ((quiet && trig_go) || (!quiet && r.seen && !(&hemp))))
    begin
      next_r.proc = 1'b1;
      next_r.lat = 5'(PROC_LAT_CYC);
    end
    else if (r.proc && r.lat != '0) next_r.lat = r.lat - 5'h1;
    else if (r.proc && (&hemp)) next_r.proc = 1'b0;
    xfer = r.proc & r.lat == '0 & r.gap == '0;
    if (r.gap != '0) next_r.gap = r.gap - 3'h1;
    else if (xfer) next_r.gap = 3'(XFER_GAP_CYC - 1);
    // Start selection and subtraction; offsets added to the result
    for (int c = 0; c < NCH; c++)
    begin
      dt = hq[c][TW-1:0] - r.t0;
      if (dt >= TW'(START2_CYC)) dt = dt - TW'(START2_CYC) + TW'(r.cfg[A_AUX][OFF_W-1:0]);
      else dt = dt + TW'(c5[OFF_W-1:0]);
      idat[c] = {hq[c][TW], dt[RW-1:0]};
      if (xfer && !hemp[c] && !ifull[c])
      begin
        next_r.hrp[c] = r.hrp[c] + 1'b1;
        ipush[c] = 1'b1;
        next_r.iwp[c] = r.iwp[c] + 1'b1;
      end
    end
    // Readout of result FIFOs; 16-bit mode gives low half then high half
    if (rd_go)
    begin
      next_r.q = '0;
      for (int c = 0; c < NCH; c++)
      begin
        if (a == (c != 0 ? A_FIFO2 : A_FIFO1) && !iemp[c])
        begin
          if (b16 && !r.half[c])
          begin
            next_r.q = DW'(iq[c][HALF_W-1:0]);
            next_r.half[c] = 1'b1;
          end
          else
          begin
            next_r.q = b16 ? DW'(iq[c][RW:HALF_W]) : DW'(iq[c]);
            next_r.half[c] = 1'b0;
            next_r.irp[c] = r.irp[c] + 1'b1;
          end
        end
      end
    end
    next_r.oe = ~p[P_OEN] | (~p[P_RD] & ~p[P_CS]);
    // Measurement timer
    if (r.trun)
    begin
      if (r.tmr <= TMR_W'(1))
      begin
        next_r.trun = 1'b0;
        next_r.tdone = 1'b1;
      end
      else next_r.tmr = r.tmr - 1'b1;
    end
    else if ((st_hit && r.cfg[A_CTRL][B_TSTART]) || (sp_hit && r.cfg[A_CTRL][B_TSTOP]))
    begin
      next_r.tmr = r.cfg[A_TIMER][TMR_W-1:0];
      next_r.trun = 1'b1;
      next_r.tdone = 1'b0;
    end
    // Interrupt flag from masked events
    next_r.irq = (|hfull & r.cfg[A_IRQ][B_IM_HFULL]) | (|ifull & r.cfg[A_IRQ][B_IM_IFULL])
      | (~p[P_PLL] & r.cfg[A_IRQ][B_IM_PLL]) | ((&hemp) & r.cfg[A_IRQ][B_IM_HEMPTY])
      | (r.tdone & r.cfg[A_IRQ][B_IM_TMR]);
    // Resets: partial keeps result FIFOs, master also clears them, power-up also configuration
    if (pu || mrst || prst)
    begin
      hpush = '0;
      ipush = '0;
      next_r.now = '0;
      next_r.t0 = '0;
      next_r.seen = 1'b0;
      next_r.sdly = '0;
      next_r.proc = 1'b0;
      next_r.lat = '0;
      next_r.gap = '0;
      next_r.hwp = '0;
      next_r.hrp = '0;
      next_r.trun = 1'b0;
      next_r.tdone = 1'b0;
      next_r.hold = (pu || mrst) ? 4'(HOLD_MST_CYC) : 4'(HOLD_PRT_CYC);
      if (pu || mrst)
      begin
        next_r.iwp = '0;
        next_r.irp = '0;
        next_r.half = '0;
      end
      if (pu) next_r.cfg = '0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst) r <= D_RST;
    else r <= next_r;
  end

  // Per-channel FIFO storage
  for (genvar c = 0; c < NCH; c++)
  begin : g_mem
    logic [TW:0] hmem [HIT_DEPTH];
    logic [RW:0] imem [IF_DEPTH];
    always_ff @(posedge ref_clk)
    begin
      if (hpush[c]) hmem[r.hwp[c][HA-1:0]] <= hdat[c];
      if (ipush[c]) imem[r.iwp[c][IA-1:0]] <= idat[c];
    end
    assign hq[c] = hmem[r.hrp[c][HA-1:0]];
    assign iq[c] = imem[r.irp[c][IA-1:0]];
  end

  assign diff_power_on = r.pwr;
  assign bus.d_dat = r.q;
  assign bus.d_en = r.oe;
  assign bus.ef = r.ef;
  assign bus.lf = r.lf;
  assign bus.irq = r.irq;
endmodule : dce_dev

// *** dce_assertions.sv ***
// Protocol checks on the pins between host and timing device
`timescale 1ns/1ps
module dce_assertions
  import dce_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst, // Asynchronous reset, high
  input wire logic cs_n, // Chip select, low
  input wire logic wr_n, // Write strobe, low
  input wire logic rd_n, // Read strobe, low
  input wire logic oen_n, // Output enable, low
  input wire logic pu_n, // Power-up reset, low
  input wire logic h_en, // Host drives data
  input wire logic d_en, // Device drives data
  input wire logic irq, // Interrupt level
  input wire logic [AW-1:0] addr, // Register address
  input wire logic [DW-1:0] h_dat, // Host data
  input wire logic [NCH-1:0] ef // Empty flags
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Bus ownership and drive
  AST_NO_FIGHT: assert property (oen_n |-> !(d_en && h_en)) else $error("both ends drive data");
  AST_OEN_DRIVE: assert property (!oen_n [*5] |-> d_en) else $error("low enable not driving");
  AST_READ_DRIVE: assert property ((!cs_n && !rd_n) [*5] |-> d_en) else $error("read not driven");
  AST_RELEASE: assert property ((rd_n && oen_n) [*5] |-> !d_en) else $error("bus not released");
  // Power-up reset sets both empty flags and clears interrupt
  AST_PU_CLEAR: assert property (!pu_n [*5] |-> ef == 2'b11 && !irq) else $error("power-up reset");
  // Host never reads an empty result store
  AST_NO_EMPTY_READ: assert property ($fell(rd_n) && !cs_n && addr[3:1] == 3'h4 |-> !ef[addr[0]])
    else $error("read of empty store");
  // Strobe framing
  AST_WR_SETUP: assert property ($fell(wr_n) |-> !cs_n && h_en && !$past(cs_n, 2)) else $error("write setup");
  AST_STROBE_LEN: assert property ($fell(rd_n) |-> (!rd_n && !cs_n) [*8]) else $error("read strobe short");
  AST_CS_HOLD: assert property ($rose(wr_n) |-> !cs_n [*3]) else $error("select hold short");
  AST_WDATA_STABLE: assert property (!wr_n && !cs_n |-> $stable(h_dat)) else $error("write data moved");
  // Main scenarios reached
  COV_FIFO_READ: cover property ($fell(rd_n) && addr == A_FIFO1);
  COV_OEN: cover property (!oen_n ##1 d_en);
  COV_IRQ: cover property ($rose(irq));
endmodule : dce_assertions

// *** test_dual_channel_edge_timing_control.sv ***
// Self-checking bench for the two-ended edge timing link
`timescale 1ns/1ps
module test_dual_channel_edge_timing_control;
  import dce_pkg::*;
  localparam logic [DW-1:0] OFF = 28'h0000010;
  localparam logic [DW-1:0] WR = 28'h0400014;
  localparam logic [DW-1:0] WF = 28'h0000018;
  logic ref_clk, rst, start_in, sw_wr, sw_rd, pll_locked, diff_power_on;
  logic [NCH-1:0] stop_in;
  logic [2:0] sw_addr;
  logic [DW-1:0] sw_wdata, sw_rdata, q;
  int n_errors, tests_run, cyc;

  dce_bus_if bus ();
  dce_host i_dce_host (.ref_clk(ref_clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(bus));
  dce_dev i_dce_dev (.ref_clk(ref_clk), .rst(rst), .start_in(start_in), .stop_in(stop_in),
    .pll_locked(pll_locked), .diff_power_on(diff_power_on), .bus(bus));
  dce_assertions i_dce_assertions (.ref_clk(ref_clk), .rst(rst), .cs_n(bus.cs_n), .wr_n(bus.wr_n),
    .rd_n(bus.rd_n), .oen_n(bus.oen_n), .pu_n(bus.pu_n), .h_en(bus.h_en), .d_en(bus.d_en), .irq(bus.irq),
    .addr(bus.addr), .h_dat(bus.h_dat), .ef(bus.ef));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic check(input logic [DW-1:0] exp, input logic [DW-1:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : check

  // Software port write and read
  task automatic sw_w(input logic [2:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask : sw_w

  task automatic sw_r(input logic [2:0] a, output logic [DW-1:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_r

  // One device bus cycle through the host, waiting for busy to clear
  task automatic dev(input logic rd, input logic [AW-1:0] a, input logic [DW-1:0] d);
    sw_w(H_WDATA, d);
    sw_w(H_CMD, {23'h0, rd, a});
    for (int i = 0; i < 60; i++)
    begin
      sw_r(H_STAT, q);
      if (q[0] === 1'b0)
        break;
    end
    check(28'h0, {27'h0, q[0]});
    if (rd)
      sw_r(H_RDATA, q);
  endtask : dev

  // Status compare: irq, load-level pair, empty pair
  task automatic st(input logic [4:0] e);
    sw_r(H_STAT, q);
    check({23'h0, e}, {23'h0, q[6:2]});
  endtask : st

  // Start at t, stops rise at t+4 and fall at t+8, then let processing finish
  task automatic pulse(input logic s, input logic [1:0] m);
    @(posedge ref_clk);
    start_in <= s;
    repeat (4) @(posedge ref_clk);
    stop_in <= m;
    repeat (4) @(posedge ref_clk);
    stop_in <= 2'b00;
    start_in <= 1'b0;
    repeat (60) @(posedge ref_clk);
  endtask : pulse

  // Main sequence
  initial
  begin
    rst = 1'b1;
    start_in = 1'b0;
    stop_in = 2'b00;
    sw_addr = 3'h0;
    sw_wdata = 28'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    pll_locked = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check(28'h0, {27'h0, diff_power_on});
    dev(0, A_EDGE, 28'h0000037);
    dev(0, A_AUX, 28'h8080000);
    check(28'h1, {27'h0, diff_power_on});
    dev(0, A_START, OFF);
    sw_w(H_PINS, 28'h60);
    dev(0, A_CTRL, 28'h0400000);
    st(5'b00011);
    pulse(1'b1, 2'b11);
    st(5'b01100);
    dev(1, A_FIFO1, 28'h0);
    check(WR, q);
    dev(1, A_FIFO1, 28'h0);
    check(WF, q);
    dev(1, A_FIFO2, 28'h0);
    check(WR, q);
    st(5'b00001);
    dev(1, A_FIFO1, 28'h0);
    sw_r(H_STAT, q);
    check(28'h1, {27'h0, q[1]});
    dev(1, A_FIFO2, 28'h0);
    check(WF, q);
    $display("test nonquiet done");
    // Rising edges gated, then partial and master resets
    sw_w(H_PINS, 28'h65);
    dev(0, A_CTRL, 28'h0400000);
    pulse(1'b1, 2'b11);
    dev(0, A_CTRL, 28'h0800000);
    st(5'b00000);
    dev(1, A_FIFO1, 28'h0);
    check(WF, q);
    st(5'b00001);
    dev(0, A_CTRL, 28'h0400000);
    st(5'b00011);
    $display("test gate_reset done");
    // Stops before start are dropped when stop waiting is on
    sw_w(H_PINS, 28'h60);
    dev(0, A_START, OFF | 28'h0040000);
    dev(0, A_CTRL, 28'h0400000);
    pulse(1'b0, 2'b11);
    st(5'b00011);
    dev(0, A_DIS, 28'h0000030);
    pulse(1'b1, 2'b11);
    st(5'b01000);
    $display("test stop_wait done");
    // Quiet mode waits for the trigger pin
    dev(0, A_START, OFF | 28'h0100000);
    dev(0, A_DIS, 28'h0000000);
    dev(0, A_CTRL, 28'h0400001);
    pulse(1'b1, 2'b00);
    pulse(1'b1, 2'b01);
    st(5'b00011);
    sw_w(H_PINS, 28'h70);
    sw_w(H_PINS, 28'h60);
    repeat (60) @(posedge ref_clk);
    st(5'b00110);
    dev(0, A_BUS, BUS16_WORD);
    dev(1, A_FIFO1, 28'h0);
    check(28'h0000014, q);
    dev(1, A_FIFO1, 28'h0);
    check(28'h0000040, q);
    dev(0, A_BUS, 28'h0000000);
    dev(1, A_FIFO1, 28'h0);
    check(WF, q);
    $display("test quiet done");
    // Measurement timer raises the interrupt when unmasked
    dev(0, A_TIMER, 28'd20);
    dev(0, A_IRQ, 28'h2000000);
    dev(0, A_CTRL, 28'h2400000);
    st(5'b00011);
    pulse(1'b1, 2'b00);
    st(5'b10011);
    dev(0, A_IRQ, 28'h0008000);
    st(5'b00011);
    @(posedge ref_clk) pll_locked <= 1'b0;
    repeat (10) @(posedge ref_clk);
    st(5'b10011);
    @(posedge ref_clk) pll_locked <= 1'b1;
    repeat (10) @(posedge ref_clk);
    st(5'b00011);
    $display("test timer done");
    // Low output enable makes the device drive the bus
    sw_w(H_PINS, 28'h40);
    repeat (10) @(posedge ref_clk);
    sw_w(H_PINS, 28'h60);
    repeat (10) @(posedge ref_clk);
    // Power-up reset clears configuration
    dev(0, A_IRQ, 28'h2000000);
    sw_r(H_STAT, q);
    check(28'h1, {27'h0, q[6]});
    sw_w(H_PINS, 28'h20);
    repeat (10) @(posedge ref_clk);
    sw_w(H_PINS, 28'h60);
    repeat (10) @(posedge ref_clk);
    check(28'h0, {27'h0, diff_power_on});
    sw_r(H_STAT, q);
    check(28'h0, {27'h0, q[6]});
    $display("test power_up done");
    close_out();
  end
endmodule : test_dual_channel_edge_timing_control
